// ---- rtl/phm_params.svh ----
// offsets, field positions and reset values for the port pin multiplexer
`ifndef PHM_PARAMS_SVH
`define PHM_PARAMS_SVH

// register offsets on the plain register port
`define PHM_OFF_DIR        3'h0
`define PHM_OFF_DATA       3'h1
`define PHM_OFF_PORT       3'h2
`define PHM_OFF_LCD_PORT   3'h3
`define PHM_OFF_LCD_CTRL2  3'h4
`define PHM_OFF_SYS_CLK2   3'h5

// field positions in the lcd port control register
`define PHM_SEG_LSB        0
`define PHM_SEG_MSB        3
`define PHM_DUTY_LSB       4
`define PHM_DUTY_MSB       5
`define PHM_CMX_BIT        6
// supply split sits in the lcd control two register
`define PHM_SUPPLY_SPLIT_BIT_BIT       0
// clock pin output enable sits in the system clock control two register
`define PHM_CLKOE_BIT      0

// reset values
`define PHM_RST_DIR        5'h00
`define PHM_RST_DATA       5'h00
`define PHM_RST_SEG        4'h0
`define PHM_RST_DUTY       2'h0
`define PHM_RST_BIT        1'b0
`define PHM_RST_RDATA      8'h00

`endif

// ---- rtl/phm_pkg.sv ----
// types shared by the port pin multiplexer files
package phm_pkg;

  typedef enum logic [1:0] {
    PHM_MODE_GP   = 2'b00,  // general-purpose pin under its direction bit
    PHM_MODE_ALT  = 2'b01,  // alternate function drives the pin
    PHM_MODE_HOLD = 2'b10   // forced input for prohibited settings
  } phm_pin_mode_t;

endpackage : phm_pkg

// ---- rtl/phm_pin_cell.sv ----
// one multiplexed port pin: input synchroniser, output and enable flops
`timescale 1ns/1ps
module phm_pin_cell (
  input  wire logic                  clk,       // system clock
  input  wire logic                  sys_rst,   // synchronous reset, active high
  input  wire phm_pkg::phm_pin_mode_t mode,     // selected pin function
  input  wire logic                  dir,       // direction bit, 1 = output
  input  wire logic                  data,      // stored output data
  input  wire logic                  alt_val,   // alternate function level
  input  wire logic                  pin_in,    // raw pin level
  output logic                       pin_out,   // level driven on the pin
  output logic                       pin_oe,    // high while the pin is driven
  output logic                       read_val   // value seen by a port read
);

  logic sync1_q;
  logic sync2_q;
  logic out_q;
  logic out_d;
  logic oe_q;
  logic oe_d;

  // ==========================================================
  // next output state
  always_comb
  begin
    out_d = data;
    oe_d  = 1'b0;
    case (mode)
      phm_pkg::PHM_MODE_GP:
      begin
        out_d = data;
        oe_d  = dir;
      end
      phm_pkg::PHM_MODE_ALT:
      begin
        out_d = alt_val;
        oe_d  = 1'b1;
      end
      phm_pkg::PHM_MODE_HOLD:
      begin
        out_d = 1'b0;
        oe_d  = 1'b0;
      end
      default:
      begin
        out_d = 1'b0;
        oe_d  = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      out_q   <= 1'b0;
      oe_q    <= 1'b0;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      out_q   <= out_d;
      oe_q    <= oe_d;
    end
  end

  assign pin_out  = out_q;
  assign pin_oe   = oe_q;
  // only the second synchroniser stage is looked at
  assign read_val = dir ? data : sync2_q;

endmodule : phm_pin_cell

// ---- rtl/phm_top.sv ----
// port pin multiplexer for clock output and lcd common pins
// Notes on behaviour
// - clock enable selects clock, else direction
// - segment select values enable common outputs
// - pin 3 general-purpose when commons off/short
// - pin 3 drives common 4 per duty
// - pin 2 drives common 3 when wide
// - pin 1 drives common 2 when wide
// - pin 0 drives common 1 when enabled
// - port read: data if output, pin otherwise
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "phm_params.svh"
module phm_top #(
  parameter bit HAS_CLK_OUT = 1'b1  // 1: clock-out variant, 0: supply-split variant
) (
  input  wire logic       clk,        // system clock, 10 MHz
  input  wire logic       sys_rst,    // synchronous reset, active high
  input  wire logic [2:0] reg_addr,   // register offset
  input  wire logic [7:0] reg_wdata,  // write data
  input  wire logic       reg_we,     // write strobe
  input  wire logic       reg_re,     // read strobe
  output logic      [7:0] reg_rdata,  // read data, cycle after the strobe
  input  wire logic [3:0] com_drv,    // common waveforms 4..1 from lcd timing
  input  wire logic [4:0] pin_in,     // pin levels, asynchronous
  output logic      [4:0] pin_out,    // pin output levels
  output logic      [4:0] pin_oe      // pin output enables
);

  logic [4:0] dir_q;
  logic [4:0] dir_d;
  logic [4:0] data_q;
  logic [4:0] data_d;
  logic [3:0] seg_q;
  logic [3:0] seg_d;
  logic [1:0] duty_q;
  logic [1:0] duty_d;
  logic       cmx_q;
  logic       cmx_d;
  logic       supply_split_bit_q;
  logic       supply_split_bit_d;
  logic       clkoe_q;
  logic       clkoe_d;
  logic       clk_div_q;
  logic       clk_div_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  logic       com_en;
  logic       seg_zero;
  logic       supply_split_bit_eff;
  logic       wide_com;
  logic [4:0] alt_val;
  logic [4:0] read_val;
  phm_pkg::phm_pin_mode_t pin_mode [5];

  // ==========================================================
  // register writes and reads
  always_comb
  begin
    dir_d   = dir_q;
    data_d  = data_q;
    seg_d   = seg_q;
    duty_d  = duty_q;
    cmx_d   = cmx_q;
    supply_split_bit_d  = supply_split_bit_q;
    clkoe_d = clkoe_q;
    if (reg_we)
    begin
      case (reg_addr)
        `PHM_OFF_DIR:       dir_d  = reg_wdata[4:0];
        `PHM_OFF_DATA:      data_d = reg_wdata[4:0];
        `PHM_OFF_LCD_PORT:
        begin
          seg_d  = reg_wdata[`PHM_SEG_MSB:`PHM_SEG_LSB];
          duty_d = reg_wdata[`PHM_DUTY_MSB:`PHM_DUTY_LSB];
          cmx_d  = reg_wdata[`PHM_CMX_BIT];
        end
        `PHM_OFF_LCD_CTRL2: supply_split_bit_d  = reg_wdata[`PHM_SUPPLY_SPLIT_BIT_BIT];
        `PHM_OFF_SYS_CLK2:  clkoe_d = reg_wdata[`PHM_CLKOE_BIT];
        default:            dir_d   = dir_q;
      endcase
    end
    // read data stand for one cycle only; direction bits are write-only
    rdata_d = 8'h00;
    if (reg_re)
    begin
      case (reg_addr)
        `PHM_OFF_DATA:      rdata_d = {3'h0, data_q};
        `PHM_OFF_PORT:      rdata_d = {3'h0, read_val};
        `PHM_OFF_LCD_PORT:  rdata_d = {1'b0, cmx_q, duty_q, seg_q};
        `PHM_OFF_LCD_CTRL2: rdata_d = {7'h00, supply_split_bit_q};
        `PHM_OFF_SYS_CLK2:  rdata_d = {7'h00, clkoe_q};
        default:            rdata_d = 8'h00;
      endcase
    end
    // clock pin runs at half the system rate: a flop cannot pass clk itself
    clk_div_d = clkoe_q ? ~clk_div_q : 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dir_q     <= `PHM_RST_DIR;
      data_q    <= `PHM_RST_DATA;
      seg_q     <= `PHM_RST_SEG;
      duty_q    <= `PHM_RST_DUTY;
      cmx_q     <= `PHM_RST_BIT;
      supply_split_bit_q    <= `PHM_RST_BIT;
      clkoe_q   <= `PHM_RST_BIT;
      clk_div_q <= `PHM_RST_BIT;
      rdata_q   <= `PHM_RST_RDATA;
    end
    else
    begin
      dir_q     <= dir_d;
      data_q    <= data_d;
      seg_q     <= seg_d;
      duty_q    <= duty_d;
      cmx_q     <= cmx_d;
      supply_split_bit_q    <= supply_split_bit_d;
      clkoe_q   <= clkoe_d;
      clk_div_q <= clk_div_d;
      rdata_q   <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ==========================================================
  // pin function decode
  always_comb
  begin
    seg_zero = (seg_q == 4'h0);
    if (HAS_CLK_OUT)
      com_en = (seg_q[2:1] == 2'b01) || (seg_q[3:1] == 3'b010) || (seg_q == 4'hc);
    else
      com_en = (seg_q == 4'h1) || (seg_q[3:1] == 3'b001) || (seg_q[3:1] == 3'b010);
    // supply split exists only on the variant without clock output
    supply_split_bit_eff = HAS_CLK_OUT ? 1'b0 : supply_split_bit_q;
    wide_com = duty_q[1] || cmx_q;
    alt_val  = {clk_div_q, com_drv};
    for (int i = 0; i < 5; i++)
      pin_mode[i] = phm_pkg::PHM_MODE_GP;
    if (HAS_CLK_OUT && clkoe_q)
      pin_mode[4] = phm_pkg::PHM_MODE_ALT;
    if (com_en)
    begin
      pin_mode[0] = phm_pkg::PHM_MODE_ALT;
      if (wide_com)
        pin_mode[1] = phm_pkg::PHM_MODE_ALT;
      if (wide_com)
        pin_mode[2] = phm_pkg::PHM_MODE_ALT;
      if (duty_q == 2'b11 || cmx_q)
        pin_mode[3] = phm_pkg::PHM_MODE_ALT;
      // prohibited split setting holds pin 3 as input
      else if (duty_q == 2'b10 && supply_split_bit_eff)
        pin_mode[3] = phm_pkg::PHM_MODE_HOLD;
    end
    else if (!seg_zero)
    begin
      // undefined segment select holds common pins as inputs
      for (int i = 0; i < 4; i++)
        pin_mode[i] = phm_pkg::PHM_MODE_HOLD;
    end
  end

  // ==========================================================
  // pin cells
  for (genvar g = 0; g < 5; g++)
  begin : g_pin
    phm_pin_cell u_cell (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .mode     (pin_mode[g]),
      .dir      (dir_q[g]),
      .data     (data_q[g]),
      .alt_val  (alt_val[g]),
      .pin_in   (pin_in[g]),
      .pin_out  (pin_out[g]),
      .pin_oe   (pin_oe[g]),
      .read_val (read_val[g])
    );
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence clk_en_write;
    HAS_CLK_OUT && reg_we && reg_addr == `PHM_OFF_SYS_CLK2 && reg_wdata[`PHM_CLKOE_BIT];
  endsequence

  sequence clk_pin_live;
    pin_oe[4] ##1 pin_oe[4] && pin_out[4] != $past(pin_out[4]);
  endsequence

  clock_pin_on_a : assert property (
    clk_en_write ##1 clkoe_q ##1 clkoe_q |-> ##1 clk_pin_live)
    else $error("clock pin did not start toggling after enable");

  clock_pin_off_a : assert property (
    !clkoe_q |=> pin_oe[4] == $past(dir_q[4]))
    else $error("pin 4 ignored its direction bit");

  seg_zero_gp_a : assert property (
    seg_q == 4'h0 |=> pin_oe[3:0] == $past(dir_q[3:0]))
    else $error("common pins driven with segment select zero");

  pin3_gp_a : assert property (
    com_en && duty_q[1] == 1'b0 && !cmx_q |=> pin_oe[3] == $past(dir_q[3]))
    else $error("pin 3 not general-purpose in short duty");

  pin3_com_a : assert property (
    com_en && duty_q == 2'b11 |=> pin_oe[3] && pin_out[3] == $past(com_drv[3]))
    else $error("pin 3 not driving common 4");

  pin2_com_a : assert property (
    com_en && wide_com |=> pin_oe[2] && pin_out[2] == $past(com_drv[2]))
    else $error("pin 2 not driving common 3");

  pin1_com_a : assert property (
    com_en && (duty_q != 2'b00 && duty_q != 2'b01 || cmx_q) |=> pin_oe[1] && pin_out[1] == $past(com_drv[1]))
    else $error("pin 1 not driving common 2");

  pin0_com_a : assert property (
    com_en |=> pin_oe[0] && pin_out[0] == $past(com_drv[0]))
    else $error("pin 0 not driving common 1");

  port_read_a : assert property (
    reg_re && reg_addr == `PHM_OFF_PORT && dir_q[0] |=> reg_rdata[0] == $past(data_q[0]))
    else $error("port read of output pin did not return stored data");

  hold_input_a : assert property (
    !com_en && !seg_zero |=> pin_oe[3:0] == 4'h0)
    else $error("undefined segment select drove a common pin");

  hold_output_low_a : assert property (
    !com_en && !seg_zero |=> pin_out[3:0] == 4'h0)
    else $error("undefined segment select left a common pin level high");

  seg_zero_data_a : assert property (
    seg_zero |=> pin_out[3:0] == $past(data_q[3:0]))
    else $error("general-purpose pins lost their stored data");

  pin3_gp_data_a : assert property (
    com_en && !duty_q[1] && !cmx_q |=> pin_out[3] == $past(data_q[3]))
    else $error("pin 3 general-purpose level differs from stored data");

  pin3_expand_a : assert property (
    com_en && cmx_q |=> pin_oe[3] && pin_out[3] == $past(com_drv[3]))
    else $error("pin 3 not driving common 4 with common expansion");

  pin3_split_gp_a : assert property (
    com_en && duty_q == 2'b10 && !cmx_q && !supply_split_bit_eff |=> pin_oe[3] == $past(dir_q[3]))
    else $error("pin 3 not general-purpose with split clear");

  pin3_hold_a : assert property (
    com_en && duty_q == 2'b10 && !cmx_q && supply_split_bit_eff |=> !pin_oe[3] && !pin_out[3])
    else $error("pin 3 driven in prohibited split setting");

  pin2_gp_a : assert property (
    com_en && !wide_com |=> pin_oe[2] == $past(dir_q[2]))
    else $error("pin 2 not general-purpose in short duty");

  pin1_gp_a : assert property (
    com_en && !wide_com |=> pin_oe[1] == $past(dir_q[1]))
    else $error("pin 1 not general-purpose in short duty");

  clock_pin_toggle_a : assert property (
    HAS_CLK_OUT && clkoe_q ##1 clkoe_q ##1 clkoe_q |=> pin_oe[4] && pin_out[4] != $past(pin_out[4]))
    else $error("clock pin stopped toggling while enabled");

  pin4_plain_a : assert property (
    !HAS_CLK_OUT |=> pin_oe[4] == $past(dir_q[4]))
    else $error("pin 4 left its direction bit on the plain variant");

  pin4_data_a : assert property (
    !HAS_CLK_OUT || !clkoe_q |=> pin_out[4] == $past(data_q[4]))
    else $error("pin 4 general-purpose level differs from stored data");

  read_idle_a : assert property (
    !reg_re |=> reg_rdata == 8'h00)
    else $error("read data stood beyond its cycle");

  // the synchroniser needs two clean cycles before a pin read is meaningful
  port_read_pin_a : assert property (
    reg_re && reg_addr == `PHM_OFF_PORT && !dir_q[1] && !$past(sys_rst) && !$past(sys_rst, 2)
    |=> reg_rdata[1] == $past(pin_in[1], 3))
    else $error("port read of input pin did not return synchronised level");

endmodule : phm_top

// ---- testbench/phm_far_side.sv ----
// far-side model: lcd common waveform source and external pin pads
`timescale 1ns/1ps
module phm_far_side (
  input  wire logic [4:0] pin_out,  // levels driven by the device
  input  wire logic [4:0] pin_oe,   // device drive enables
  input  wire logic [4:0] ext_lvl,  // external source level on undriven pins
  input  wire logic [3:0] com_pat,  // common waveform levels to hand over
  output logic      [3:0] com_drv,  // common waveforms into the device
  output logic      [4:0] pin_in    // pad levels seen by the device
);
  assign com_drv = com_pat;
  // pad level loops back
  // a driven pad shows the device level, while a read of an output pin returns the stored data, not the pad
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : phm_far_side

// ---- testbench/port_h_lcd_common_pin_mux_bench.sv ----
// self-checking bench for the port pin multiplexer
`timescale 1ns/1ps
`include "phm_params.svh"
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module port_h_lcd_common_pin_mux_bench;
  logic       clk;
  logic       sys_rst;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_we;
  logic       reg_re;
  logic [7:0] reg_rdata;
  logic [3:0] com_drv;
  logic [3:0] com_pat;
  logic [4:0] pin_in;
  logic [4:0] pin_out;
  logic [4:0] pin_oe;
  logic [4:0] ext_lvl;
  logic [3:0] com_drv2;
  logic [4:0] pin_in2;
  logic [4:0] pin_out2;
  logic [4:0] pin_oe2;
  logic [7:0] rv;
  logic       lvl_a;
  int         mismatches;
  int         samples_checked;
  // {lcd port control, expected enables, expected levels} with dir 1 and data 0
  logic [15:0] tbl [9] = '{16'h00f0, 16'h02f1, 16'h15f1, 16'h52ff, 16'h24f7,
                           16'h3cff, 16'h6bff, 16'h0100, 16'h3600};
  // the same settings on the variant with supply split and no clock pin: {enables, levels}
  logic [7:0]  tbl2 [9] = '{8'hf0, 8'hf1, 8'hf1, 8'hff, 8'hf7, 8'h00, 8'h00, 8'hf1, 8'h00};

  phm_top uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
               .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .com_drv(com_drv),
               .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  phm_far_side far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
                    .com_pat(com_pat), .com_drv(com_drv), .pin_in(pin_in));
  phm_top #(.HAS_CLK_OUT(1'b0)) uut2 (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
               .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(),
               .com_drv(com_drv2), .pin_in(pin_in2), .pin_out(pin_out2), .pin_oe(pin_oe2));
  phm_far_side far2 (.pin_out(pin_out2), .pin_oe(pin_oe2), .ext_lvl(ext_lvl),
                     .com_pat(com_pat), .com_drv(com_drv2), .pin_in(pin_in2));

  // ==========================================================
  // clock and bus tasks
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clk);
    reg_we    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge clk);
    reg_re   <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  // register update plus pin flop, then sample mid-cycle
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic test_done();
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // ==========================================================
  // tests
  initial
  begin
    sys_rst   = 1'b1;
    reg_addr  = 3'h0;
    reg_wdata = 8'h00;
    reg_we    = 1'b0;
    reg_re    = 1'b0;
    com_pat   = 4'hf;
    ext_lvl   = 5'h0a;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    `CHK(pin_oe, 5'h00)
    `CHK(pin_oe2, 5'h00)
    wr(`PHM_OFF_DATA, 8'h15);
    wr(`PHM_OFF_DIR, 8'h05);
    settle();
    `CHK(pin_oe, 5'h05)
    `CHK(pin_out, 5'h15)
    rd(`PHM_OFF_PORT, rv);
    `CHK(rv, 8'h0f)
    rd(`PHM_OFF_DATA, rv);
    `CHK(rv, 8'h15)
    rd(`PHM_OFF_DIR, rv);
    `CHK(rv, 8'h00)
    rd(3'h6, rv);
    `CHK(rv, 8'h00)
    wr(`PHM_OFF_DIR, 8'h10);
    settle();
    `CHK(pin_oe[4], 1'b1)
    `CHK(pin_out[4], 1'b1)
    wr(`PHM_OFF_SYS_CLK2, 8'h01);
    settle();
    lvl_a = pin_out[4];
    @(negedge clk);
    `CHK(pin_oe[4], 1'b1)
    `CHK(lvl_a ^ pin_out[4], 1'b1)
    `CHK({pin_oe2[4], pin_out2[4]}, 2'b11)
    wr(`PHM_OFF_SYS_CLK2, 8'h00);
    wr(`PHM_OFF_DIR, 8'h00);
    settle();
    `CHK(pin_oe[4], 1'b0)
    `CHK(pin_oe2[4], 1'b0)
    wr(`PHM_OFF_DIR, 8'h0f);
    wr(`PHM_OFF_DATA, 8'h00);
    for (int i = 0; i < 9; i++)
    begin
      wr(`PHM_OFF_LCD_PORT, tbl[i][15:8]);
      settle();
      `CHK(pin_oe[3:0], tbl[i][7:4])
      `CHK(pin_out[3:0], tbl[i][3:0])
      `CHK({pin_oe2[3:0], pin_out2[3:0]}, tbl2[i])
    end
    // split set only with a legal duty
    wr(`PHM_OFF_LCD_PORT, 8'h3c);
    wr(`PHM_OFF_LCD_CTRL2, 8'h01);
    com_pat <= 4'h5;
    settle();
    `CHK(pin_out[3:0], 4'h5)
    `CHK(pin_oe[3:0], 4'hf)
    `CHK({pin_oe2[3:0], pin_out2[3:0]}, 8'h00)
    // common expansion with the split set is legal on both variants
    wr(`PHM_OFF_LCD_PORT, 8'h64);
    settle();
    `CHK({pin_oe[3:0], pin_out[3:0]}, 8'hf5)
    `CHK({pin_oe2[3:0], pin_out2[3:0]}, 8'hf5)
    rd(`PHM_OFF_LCD_PORT, rv);
    `CHK(rv, 8'h64)
    rd(`PHM_OFF_LCD_CTRL2, rv);
    `CHK(rv, 8'h01)
    rd(`PHM_OFF_SYS_CLK2, rv);
    `CHK(rv, 8'h00)
    test_done();
  end

  // run needs well under 1000 cycles
  initial
  begin
    #1_000_000;
    mismatches++;
    test_done();
  end
endmodule : port_h_lcd_common_pin_mux_bench
